//--- inc/pfm_pkg.sv
/*
  pfm_pkg: register map, field layout, function codes and pin indices of the
  port A / port B pin-function multiplexer.
  assumes: an APB register bus with 32-bit data; only the low byte is used.
*/
`default_nettype none
package pfm_pkg;
  // register byte addresses on the APB window
  localparam logic [11:0] PORT_A_LOW_PIN_SELECT_ADDR = 12'h000;
  localparam logic [11:0] PORT_A_HIGH_PIN_SELECT_ADDR = 12'h004;
  localparam logic [11:0] PORT_B_LOW_PIN_SELECT_ADDR = 12'h008;
  localparam logic [11:0] PORT_B_HIGH_PIN_SELECT_ADDR = 12'h00C;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // field lsb positions inside a high select register
  localparam int LINE7_SEL_LSB = 6;
  localparam int LINE6_SEL_LSB = 4;
  localparam int LINE5_SEL_LSB = 2;
  localparam int LINE4_SEL_LSB = 0;

  // two-bit function codes
  localparam logic [1:0] CODE_0 = 2'h0;
  localparam logic [1:0] CODE_1 = 2'h1;
  localparam logic [1:0] CODE_2 = 2'h2;
  localparam logic [1:0] CODE_3 = 2'h3;

  // pin index in the internal 8-bit pin vectors
  localparam int LINE_A4 = 0;
  localparam int LINE_A5 = 1;
  localparam int LINE_A6 = 2;
  localparam int LINE_A7 = 3;
  localparam int LINE_B4 = 4;
  localparam int LINE_B5 = 5;
  localparam int LINE_B6 = 6;
  localparam int LINE_B7 = 7;

  // index of each digital peripheral input in the routed vector
  localparam int DI_IRQ0_A7 = 0;
  localparam int DI_TCLK2_A7 = 1;
  localparam int DI_TCLK1_A6 = 2;
  localparam int DI_CAPT_A6 = 3;
  localparam int DI_HALL3_A5 = 4;
  localparam int DI_HALL2_A4 = 5;
  localparam int DI_HALL2_B6 = 6;
  localparam int DI_HALL3_B5 = 7;
  localparam int DI_HALL1_B7 = 8;
  localparam int DI_CAPT_B4 = 9;
  localparam int DI_RX_B4 = 10;
  localparam int DI_WIDTH = 11;

  // index of each analog switch enable
  localparam int AS_CH7 = 0;
  localparam int AS_CH8 = 1;
  localparam int AS_CMP3 = 2;
  localparam int AS_CH2 = 3;
  localparam int AS_CMP2 = 4;
  localparam int AS_CH4 = 5;
  localparam int AS_OPAMP = 6;
  localparam int AS_WIDTH = 7;
endpackage : pfm_pkg
`default_nettype wire

//--- hw/pfm_port_ab_mux.sv
/*
  pfm_port_ab_mux: APB-programmed pin-function multiplexer for port A and
  port B lines 4 to 7, with four 8-bit selection registers.
  assumes: one 25 MHz clock, pins arrive asynchronously, peripherals and the
  gpio port logic sit on the same clock; pin output enables are active low.
*/
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pfm_port_ab_mux (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // package pins, index 0..3 = port A lines 4..7, 4..7 = port B lines 4..7
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_n_o,
  // gpio port logic
  input wire logic [7:0] gpio_out_i,
  input wire logic [7:0] gpio_dir_in_i,
  output logic [7:0] gpio_in_o,
  // peripheral outputs toward the pins
  input wire logic timer_pwm_out_0_i,
  input wire logic timer_pwm_out_0_inv_i,
  input wire logic timer_pwm_out_2_i,
  input wire logic timer_pwm_out_2_inv_i,
  input wire logic timer_pwm_out_3_i,
  input wire logic timer_pwm_out_3_inv_i,
  input wire logic hall_a_output_i,
  input wire logic hall_b_output_i,
  input wire logic serial_tx_i,
  input wire logic serial_tx_drive_i,
  // digital peripheral inputs taken from the pins
  output logic ext_irq_in_0_a7_o,
  output logic timer_clock_in_2_a7_o,
  output logic timer_clock_in_1_a6_o,
  output logic capture_timer_in_a6_o,
  output logic capture_timer_in_b4_o,
  output logic hall_in_1_b7_o,
  output logic hall_in_2_a4_o,
  output logic hall_in_2_b6_o,
  output logic hall_in_3_a5_o,
  output logic hall_in_3_b5_o,
  output logic serial_rx_b4_o,
  // analog switch enables
  output logic analog_ch_7_sel_o,
  output logic analog_ch_8_sel_o,
  output logic analog_ch_2_sel_o,
  output logic analog_ch_4_sel_o,
  output logic comparator3_pos_in_sel_o,
  output logic comparator2_pos_in_sel_o,
  output logic opamp_output_sel_o
);

  typedef struct packed {
    logic [7:0] port_a_low_pin_select;
    logic [7:0] port_a_high_pin_select;
    logic [7:0] port_b_low_pin_select;
    logic [7:0] port_b_high_pin_select;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] gpio_in;
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
    logic [pfm_pkg::DI_WIDTH-1:0] dig_in;
    logic [pfm_pkg::AS_WIDTH-1:0] ana_sel;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pfm_state_type;

  pfm_state_type state_q;
  pfm_state_type state_d;

  function automatic logic [1:0] field(input logic [7:0] reg_val, input int lsb);
    field = reg_val[lsb +: 2];
  endfunction : field

  function automatic logic addr_hit(input logic [11:0] addr);
    addr_hit = (addr == pfm_pkg::PORT_A_LOW_PIN_SELECT_ADDR) ||
               (addr == pfm_pkg::PORT_A_HIGH_PIN_SELECT_ADDR) ||
               (addr == pfm_pkg::PORT_B_LOW_PIN_SELECT_ADDR) ||
               (addr == pfm_pkg::PORT_B_HIGH_PIN_SELECT_ADDR);
  endfunction : addr_hit

  logic [1:0] sel_a7;
  logic [1:0] sel_a6;
  logic [1:0] sel_a5;
  logic [1:0] sel_a4;
  logic [1:0] sel_b7;
  logic [1:0] sel_b6;
  logic [1:0] sel_b5;
  logic [1:0] sel_b4;
  logic setup_phase;
  logic access_done;

  assign sel_a7 = field(state_q.port_a_high_pin_select, pfm_pkg::LINE7_SEL_LSB);
  assign sel_a6 = field(state_q.port_a_high_pin_select, pfm_pkg::LINE6_SEL_LSB);
  assign sel_a5 = field(state_q.port_a_high_pin_select, pfm_pkg::LINE5_SEL_LSB);
  assign sel_a4 = field(state_q.port_a_high_pin_select, pfm_pkg::LINE4_SEL_LSB);
  assign sel_b7 = field(state_q.port_b_high_pin_select, pfm_pkg::LINE7_SEL_LSB);
  assign sel_b6 = field(state_q.port_b_high_pin_select, pfm_pkg::LINE6_SEL_LSB);
  assign sel_b5 = field(state_q.port_b_high_pin_select, pfm_pkg::LINE5_SEL_LSB);
  assign sel_b4 = field(state_q.port_b_high_pin_select, pfm_pkg::LINE4_SEL_LSB);

  // one wait-free access phase: pready is raised by the setup cycle
  assign setup_phase = psel_i && !penable_i && !state_q.pready;
  assign access_done = psel_i && penable_i && state_q.pready;

  always_comb begin
    state_d = state_q;

    // pins are asynchronous; only sync2 feeds any logic
    state_d.sync1 = pin_i;
    state_d.sync2 = state_q.sync1;
    state_d.gpio_in = state_q.sync2;

    // apb register access
    state_d.pready = setup_phase;
    if (setup_phase) begin
      state_d.pslverr = !addr_hit(paddr_i);
      case (paddr_i)
        pfm_pkg::PORT_A_LOW_PIN_SELECT_ADDR: state_d.prdata = {24'h00_0000, state_q.port_a_low_pin_select};
        pfm_pkg::PORT_A_HIGH_PIN_SELECT_ADDR: state_d.prdata = {24'h00_0000, state_q.port_a_high_pin_select};
        pfm_pkg::PORT_B_LOW_PIN_SELECT_ADDR: state_d.prdata = {24'h00_0000, state_q.port_b_low_pin_select};
        pfm_pkg::PORT_B_HIGH_PIN_SELECT_ADDR: state_d.prdata = {24'h00_0000, state_q.port_b_high_pin_select};
        default: state_d.prdata = pfm_pkg::READ_ZERO;
      endcase
    end else if (access_done) begin
      state_d.pslverr = 1'b0;
      state_d.prdata = pfm_pkg::READ_ZERO;
    end
    if (access_done && pwrite_i) begin
      case (paddr_i)
        pfm_pkg::PORT_A_LOW_PIN_SELECT_ADDR: state_d.port_a_low_pin_select = pwdata_i[7:0];
        pfm_pkg::PORT_A_HIGH_PIN_SELECT_ADDR: state_d.port_a_high_pin_select = pwdata_i[7:0];
        pfm_pkg::PORT_B_LOW_PIN_SELECT_ADDR: state_d.port_b_low_pin_select = pwdata_i[7:0];
        pfm_pkg::PORT_B_HIGH_PIN_SELECT_ADDR: state_d.port_b_high_pin_select = pwdata_i[7:0];
        default: state_d.pslverr = 1'b0;
      endcase
    end

    // default: every line is gpio, analog switches open, routed inputs low
    state_d.pin_out = gpio_out_i;
    state_d.pin_oe_n = gpio_dir_in_i;
    state_d.dig_in = '0;
    state_d.ana_sel = '0;

    // port A line 7
    case (sel_a7)
      pfm_pkg::CODE_0: begin
        // shared digital inputs only see the pin when it is set as input
        state_d.dig_in[pfm_pkg::DI_IRQ0_A7] = state_q.sync2[pfm_pkg::LINE_A7] && gpio_dir_in_i[pfm_pkg::LINE_A7];
        state_d.dig_in[pfm_pkg::DI_TCLK2_A7] = state_q.sync2[pfm_pkg::LINE_A7] && gpio_dir_in_i[pfm_pkg::LINE_A7];
      end
      pfm_pkg::CODE_1: begin
        state_d.ana_sel[pfm_pkg::AS_CH7] = 1'b1;
        state_d.pin_oe_n[pfm_pkg::LINE_A7] = 1'b1;
      end
      pfm_pkg::CODE_2: begin
        state_d.pin_out[pfm_pkg::LINE_A7] = timer_pwm_out_0_i;
        state_d.pin_oe_n[pfm_pkg::LINE_A7] = 1'b0;
      end
      default: begin
        state_d.pin_out[pfm_pkg::LINE_A7] = timer_pwm_out_0_inv_i;
        state_d.pin_oe_n[pfm_pkg::LINE_A7] = 1'b0;
      end
    endcase

    // port A line 6
    case (sel_a6)
      pfm_pkg::CODE_0: begin
        state_d.dig_in[pfm_pkg::DI_TCLK1_A6] = state_q.sync2[pfm_pkg::LINE_A6] && gpio_dir_in_i[pfm_pkg::LINE_A6];
        state_d.dig_in[pfm_pkg::DI_CAPT_A6] = state_q.sync2[pfm_pkg::LINE_A6] && gpio_dir_in_i[pfm_pkg::LINE_A6];
      end
      pfm_pkg::CODE_1: begin
        state_d.ana_sel[pfm_pkg::AS_CH8] = 1'b1;
        state_d.pin_oe_n[pfm_pkg::LINE_A6] = 1'b1;
      end
      pfm_pkg::CODE_2: begin
        state_d.pin_out[pfm_pkg::LINE_A6] = timer_pwm_out_2_i;
        state_d.pin_oe_n[pfm_pkg::LINE_A6] = 1'b0;
      end
      default: begin
        state_d.pin_out[pfm_pkg::LINE_A6] = hall_b_output_i;
        state_d.pin_oe_n[pfm_pkg::LINE_A6] = 1'b0;
      end
    endcase

    // port A line 5
    case (sel_a5)
      pfm_pkg::CODE_1: begin
        state_d.ana_sel[pfm_pkg::AS_CMP3] = 1'b1;
        state_d.pin_oe_n[pfm_pkg::LINE_A5] = 1'b1;
      end
      pfm_pkg::CODE_2: begin
        state_d.ana_sel[pfm_pkg::AS_CH2] = 1'b1;
        state_d.pin_oe_n[pfm_pkg::LINE_A5] = 1'b1;
      end
      default: begin
        state_d.dig_in[pfm_pkg::DI_HALL3_A5] = state_q.sync2[pfm_pkg::LINE_A5] && gpio_dir_in_i[pfm_pkg::LINE_A5];
      end
    endcase

    // port A line 4
    case (sel_a4)
      pfm_pkg::CODE_1: begin
        state_d.ana_sel[pfm_pkg::AS_CMP2] = 1'b1;
        state_d.pin_oe_n[pfm_pkg::LINE_A4] = 1'b1;
      end
      pfm_pkg::CODE_2: begin
        state_d.ana_sel[pfm_pkg::AS_CH4] = 1'b1;
        state_d.pin_oe_n[pfm_pkg::LINE_A4] = 1'b1;
      end
      default: begin
        state_d.dig_in[pfm_pkg::DI_HALL2_A4] = state_q.sync2[pfm_pkg::LINE_A4] && gpio_dir_in_i[pfm_pkg::LINE_A4];
      end
    endcase

    // port B line 7; code 00 is treated like 11, as gpio with hall 1
    case (sel_b7)
      pfm_pkg::CODE_1: begin
        state_d.pin_out[pfm_pkg::LINE_B7] = timer_pwm_out_2_i;
        state_d.pin_oe_n[pfm_pkg::LINE_B7] = 1'b0;
      end
      pfm_pkg::CODE_2: begin
        state_d.pin_out[pfm_pkg::LINE_B7] = timer_pwm_out_2_inv_i;
        state_d.pin_oe_n[pfm_pkg::LINE_B7] = 1'b0;
      end
      default: begin
        state_d.dig_in[pfm_pkg::DI_HALL1_B7] = state_q.sync2[pfm_pkg::LINE_B7] && gpio_dir_in_i[pfm_pkg::LINE_B7];
      end
    endcase

    // port B line 6
    case (sel_b6)
      pfm_pkg::CODE_0: begin
        state_d.dig_in[pfm_pkg::DI_HALL2_B6] = state_q.sync2[pfm_pkg::LINE_B6] && gpio_dir_in_i[pfm_pkg::LINE_B6];
      end
      pfm_pkg::CODE_1: begin
        state_d.pin_out[pfm_pkg::LINE_B6] = timer_pwm_out_3_i;
        state_d.pin_oe_n[pfm_pkg::LINE_B6] = 1'b0;
      end
      pfm_pkg::CODE_2: begin
        state_d.pin_out[pfm_pkg::LINE_B6] = timer_pwm_out_3_inv_i;
        state_d.pin_oe_n[pfm_pkg::LINE_B6] = 1'b0;
      end
      default: begin
        // op-amp drives the pin through its own analog path
        state_d.ana_sel[pfm_pkg::AS_OPAMP] = 1'b1;
        state_d.pin_oe_n[pfm_pkg::LINE_B6] = 1'b1;
      end
    endcase

    // port B line 5
    case (sel_b5)
      pfm_pkg::CODE_0: begin
        state_d.dig_in[pfm_pkg::DI_HALL3_B5] = state_q.sync2[pfm_pkg::LINE_B5] && gpio_dir_in_i[pfm_pkg::LINE_B5];
      end
      pfm_pkg::CODE_1: begin
        state_d.pin_out[pfm_pkg::LINE_B5] = timer_pwm_out_0_i;
        state_d.pin_oe_n[pfm_pkg::LINE_B5] = 1'b0;
      end
      pfm_pkg::CODE_2: begin
        state_d.pin_out[pfm_pkg::LINE_B5] = hall_a_output_i;
        state_d.pin_oe_n[pfm_pkg::LINE_B5] = 1'b0;
      end
      default: begin
        state_d.pin_out[pfm_pkg::LINE_B5] = serial_tx_i;
        state_d.pin_oe_n[pfm_pkg::LINE_B5] = 1'b0;
      end
    endcase

    // port B line 4
    case (sel_b4)
      pfm_pkg::CODE_1: begin
        state_d.pin_out[pfm_pkg::LINE_B4] = timer_pwm_out_0_i;
        state_d.pin_oe_n[pfm_pkg::LINE_B4] = 1'b0;
      end
      pfm_pkg::CODE_2: begin
        // single-wire serial: the uart turns the line round itself
        state_d.pin_out[pfm_pkg::LINE_B4] = serial_tx_i;
        state_d.pin_oe_n[pfm_pkg::LINE_B4] = !serial_tx_drive_i;
        state_d.dig_in[pfm_pkg::DI_RX_B4] = state_q.sync2[pfm_pkg::LINE_B4];
      end
      default: begin
        state_d.dig_in[pfm_pkg::DI_CAPT_B4] = state_q.sync2[pfm_pkg::LINE_B4] && gpio_dir_in_i[pfm_pkg::LINE_B4];
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= '0;
      state_q.port_a_low_pin_select <= pfm_pkg::SELECT_RESET;
      state_q.port_a_high_pin_select <= pfm_pkg::SELECT_RESET;
      state_q.port_b_low_pin_select <= pfm_pkg::SELECT_RESET;
      state_q.port_b_high_pin_select <= pfm_pkg::SELECT_RESET;
      // pins stay released until the first clocked update
      state_q.pin_oe_n <= 8'hFF;
    end else begin
      state_q <= state_d;
    end
  end

  assign prdata_o = state_q.prdata;
  assign pready_o = state_q.pready;
  assign pslverr_o = state_q.pslverr;
  assign pin_o = state_q.pin_out;
  assign pin_oe_n_o = state_q.pin_oe_n;
  assign gpio_in_o = state_q.gpio_in;
  assign ext_irq_in_0_a7_o = state_q.dig_in[pfm_pkg::DI_IRQ0_A7];
  assign timer_clock_in_2_a7_o = state_q.dig_in[pfm_pkg::DI_TCLK2_A7];
  assign timer_clock_in_1_a6_o = state_q.dig_in[pfm_pkg::DI_TCLK1_A6];
  assign capture_timer_in_a6_o = state_q.dig_in[pfm_pkg::DI_CAPT_A6];
  assign capture_timer_in_b4_o = state_q.dig_in[pfm_pkg::DI_CAPT_B4];
  assign hall_in_1_b7_o = state_q.dig_in[pfm_pkg::DI_HALL1_B7];
  assign hall_in_2_a4_o = state_q.dig_in[pfm_pkg::DI_HALL2_A4];
  assign hall_in_2_b6_o = state_q.dig_in[pfm_pkg::DI_HALL2_B6];
  assign hall_in_3_a5_o = state_q.dig_in[pfm_pkg::DI_HALL3_A5];
  assign hall_in_3_b5_o = state_q.dig_in[pfm_pkg::DI_HALL3_B5];
  assign serial_rx_b4_o = state_q.dig_in[pfm_pkg::DI_RX_B4];
  assign analog_ch_7_sel_o = state_q.ana_sel[pfm_pkg::AS_CH7];
  assign analog_ch_8_sel_o = state_q.ana_sel[pfm_pkg::AS_CH8];
  assign analog_ch_2_sel_o = state_q.ana_sel[pfm_pkg::AS_CH2];
  assign analog_ch_4_sel_o = state_q.ana_sel[pfm_pkg::AS_CH4];
  assign comparator3_pos_in_sel_o = state_q.ana_sel[pfm_pkg::AS_CMP3];
  assign comparator2_pos_in_sel_o = state_q.ana_sel[pfm_pkg::AS_CMP2];
  assign opamp_output_sel_o = state_q.ana_sel[pfm_pkg::AS_OPAMP];

endmodule : pfm_port_ab_mux
`default_nettype wire

//--- test/pfm_port_ab_mux_assertions.sv
/*
  pfm_port_ab_mux_assertions: port-level checker for the pin-function mux.
  assumes: bound to pfm_port_ab_mux; apb writes complete when pready_o is high.
*/
`timescale 1ns/1ns
`default_nettype none
module pfm_port_ab_mux_assertions (
  // clock, reset and apb
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  // pins and peripherals
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n_o,
  input wire logic timer_pwm_out_0_i,
  input wire logic timer_pwm_out_0_inv_i,
  input wire logic timer_pwm_out_2_inv_i,
  input wire logic hall_a_output_i,
  input wire logic hall_b_output_i,
  input wire logic analog_ch_2_sel_o,
  input wire logic comparator2_pos_in_sel_o,
  input wire logic opamp_output_sel_o
);
  logic [7:0] sa_q;
  logic [7:0] sb_q;
  logic wr_done;
  assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
  // shadows of the two routing registers, updated on the design's own write edge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sa_q <= 8'h00;
      sb_q <= 8'h00;
    end else if (wr_done && paddr_i == pfm_pkg::PORT_A_HIGH_PIN_SELECT_ADDR) begin
      sa_q <= pwdata_i[7:0];
    end else if (wr_done && paddr_i == pfm_pkg::PORT_B_HIGH_PIN_SELECT_ADDR) begin
      sb_q <= pwdata_i[7:0];
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  AST_PA7_PWM_INV: assert property ($past(sa_q[7:6]) == 2'h3 |->
    pin_o[3] == $past(timer_pwm_out_0_inv_i) && !pin_oe_n_o[3]) else $error("port a line7 not on inverted pwm 0");
  AST_PA6_HALL_B: assert property ($past(sa_q[5:4]) == 2'h3 |->
    pin_o[2] == $past(hall_b_output_i) && !pin_oe_n_o[2]) else $error("port a line6 not on hall b output");
  AST_PA5_ANALOG: assert property ($past(sa_q[3:2]) == 2'h2 |->
    analog_ch_2_sel_o && pin_oe_n_o[1]) else $error("port a line5 not on analog 2");
  AST_PA4_CMP: assert property ($past(sa_q[1:0]) == 2'h1 |->
    comparator2_pos_in_sel_o && pin_oe_n_o[0]) else $error("port a line4 not on comparator 2");
  AST_PB6_OPAMP: assert property ($past(sb_q[5:4]) == 2'h3 |->
    opamp_output_sel_o && pin_oe_n_o[6]) else $error("port b line6 not on op-amp output");
  AST_PB5_HALL_A: assert property ($past(sb_q[3:2]) == 2'h2 |->
    pin_o[5] == $past(hall_a_output_i) && !pin_oe_n_o[5]) else $error("port b line5 not on hall a output");
  AST_PB4_PWM: assert property ($past(sb_q[1:0]) == 2'h1 |->
    pin_o[4] == $past(timer_pwm_out_0_i) && !pin_oe_n_o[4]) else $error("port b line4 not on pwm 0");
  AST_PB7_PWM_INV: assert property ($past(sb_q[7:6]) == 2'h2 |->
    pin_o[7] == $past(timer_pwm_out_2_inv_i) && !pin_oe_n_o[7]) else $error("port b line7 not on inverted pwm 2");
  AST_READY_ONE: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("ready not a single cycle after setup");
  AST_READ_BACK: assert property (psel_i && penable_i && pready_o && !pwrite_i &&
    paddr_i == pfm_pkg::PORT_A_HIGH_PIN_SELECT_ADDR |-> prdata_o == {24'h00_0000, sa_q})
    else $error("port a high select reads back wrong");
endmodule : pfm_port_ab_mux_assertions
bind pfm_port_ab_mux pfm_port_ab_mux_assertions i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .timer_pwm_out_0_i(timer_pwm_out_0_i),
  .timer_pwm_out_0_inv_i(timer_pwm_out_0_inv_i), .timer_pwm_out_2_inv_i(timer_pwm_out_2_inv_i),
  .hall_a_output_i(hall_a_output_i), .hall_b_output_i(hall_b_output_i), .analog_ch_2_sel_o(analog_ch_2_sel_o),
  .comparator2_pos_in_sel_o(comparator2_pos_in_sel_o), .opamp_output_sel_o(opamp_output_sel_o));
`default_nettype wire

//--- test/pfm_far_side.sv
/*
  pfm_far_side: package pins and peripheral drivers around the mux.
  assumes: the bench picks a two-bit phase and the level outside released pins.
*/
`timescale 1ns/1ns
`default_nettype none
module pfm_far_side (
  // bench control
  input wire logic [1:0] ph_i,
  input wire logic [7:0] ext_i,
  // pins
  input wire logic [7:0] pin_drv_i,
  input wire logic [7:0] pin_oe_n_i,
  output logic [7:0] pin_lvl_o,
  // peripheral drive: txd, tx, hall b, hall a, pwm3 inv, pwm3, pwm2 inv, pwm2, pwm0 inv, pwm0
  output logic [9:0] per_o
);
  logic x;
  assign x = ph_i[0] ^ ph_i[1];
  // released pins show the outside level, so a stale drive value cannot pass
  assign pin_lvl_o = (pin_oe_n_i & ext_i) | (~pin_oe_n_i & pin_drv_i);
  // distinct levels for the sources that share a line, so a swapped route shows up in some phase
  assign per_o = {ph_i[0], ph_i[1], ph_i[0], ~ph_i[1], ~x, x, ~ph_i[1], ph_i[1], ~ph_i[0], ph_i[0]};
endmodule : pfm_far_side
`default_nettype wire

//--- test/pfm_port_ab_mux_test.sv
/*
  pfm_port_ab_mux_test: apb register and pin routing tests for the mux.
  assumes: pfm_far_side stands at the pins; 25 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module pfm_port_ab_mux_test;
  logic clk_i, reset_n_i, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] pin_i, pin_o, pin_oe_n, gpio_out, gpio_dir, gpio_in, ext;
  logic [1:0] ph;
  logic [9:0] per;
  logic [10:0] r;
  logic [6:0] sel;
  int errors, samples_checked, c, p;

  pfm_port_ab_mux i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n), .gpio_out_i(gpio_out),
    .gpio_dir_in_i(gpio_dir), .gpio_in_o(gpio_in), .timer_pwm_out_0_i(per[0]), .timer_pwm_out_0_inv_i(per[1]),
    .timer_pwm_out_2_i(per[2]), .timer_pwm_out_2_inv_i(per[3]), .timer_pwm_out_3_i(per[4]),
    .timer_pwm_out_3_inv_i(per[5]), .hall_a_output_i(per[6]), .hall_b_output_i(per[7]), .serial_tx_i(per[8]),
    .serial_tx_drive_i(per[9]), .ext_irq_in_0_a7_o(r[0]), .timer_clock_in_2_a7_o(r[1]),
    .timer_clock_in_1_a6_o(r[2]), .capture_timer_in_a6_o(r[3]), .hall_in_3_a5_o(r[4]),
    .hall_in_2_a4_o(r[5]), .hall_in_2_b6_o(r[6]), .hall_in_3_b5_o(r[7]), .hall_in_1_b7_o(r[8]),
    .capture_timer_in_b4_o(r[9]), .serial_rx_b4_o(r[10]), .analog_ch_7_sel_o(sel[6]),
    .analog_ch_8_sel_o(sel[5]), .analog_ch_2_sel_o(sel[4]), .analog_ch_4_sel_o(sel[3]),
    .comparator3_pos_in_sel_o(sel[2]), .comparator2_pos_in_sel_o(sel[1]), .opamp_output_sel_o(sel[0]));
  pfm_far_side i_far (.ph_i(ph), .ext_i(ext), .pin_drv_i(pin_o), .pin_oe_n_i(pin_oe_n), .pin_lvl_o(pin_i),
    .per_o(per));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at a rising edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task check_pins(input logic [1:0] k, input logic [1:0] q);
    logic a, b, x;
    logic [7:0] eo, ee;
    logic [6:0] es;
    a = q[0];
    b = q[1];
    x = a ^ b;
    eo = gpio_out;
    ee = gpio_dir;
    es = 7'h00;
    case (k)
      2'h1: begin
        eo[7:4] = {b, x, a, a};
        ee = 8'h0F;
        es = 7'b110_0110;
      end
      2'h2: begin
        eo[7:2] = {~b, ~x, ~b, b, a, b};
        ee = {3'b000, ~a, 4'h3};
        es = 7'b001_1000;
      end
      2'h3: begin
        eo[3:2] = {~a, a};
        eo[5] = b;
        ee[6:5] = 2'b10;
        ee[3:2] = 2'b00;
        es = 7'b000_0001;
      end
      default: ;
    endcase
    chk(pin_oe_n, ee);
    chk(pin_o & ~ee, eo & ~ee);
    chk(sel, es);
  endtask : check_pins

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    summarize();
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    reset_n_i = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    gpio_out = 8'h3C;
    gpio_dir = 8'hA5;
    ext = 8'h96;
    ph = 2'h0;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (c = 0; c < 4; c++) begin
      xfer(1'b0, 12'(4 * c), 32'h0000_0000);
      chk(rd, 32'h0000_0000);
    end
    xfer(1'b1, pfm_pkg::PORT_A_LOW_PIN_SELECT_ADDR, 32'hFFFF_FFA5);
    xfer(1'b1, pfm_pkg::PORT_B_LOW_PIN_SELECT_ADDR, 32'h0000_005A);
    xfer(1'b1, 12'h010, 32'h0000_00FF);
    chk(er, 1'b1);
    xfer(1'b0, 12'h010, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(er, 1'b1);
    xfer(1'b0, pfm_pkg::PORT_A_LOW_PIN_SELECT_ADDR, 32'h0000_0000);
    chk(rd, 32'h0000_00A5);
    xfer(1'b0, pfm_pkg::PORT_B_LOW_PIN_SELECT_ADDR, 32'h0000_0000);
    chk(rd, 32'h0000_005A);
    for (c = 0; c < 4; c++) begin
      xfer(1'b1, pfm_pkg::PORT_A_HIGH_PIN_SELECT_ADDR, {24'h00_0000, {4{2'(c)}}});
      xfer(1'b1, pfm_pkg::PORT_B_HIGH_PIN_SELECT_ADDR, {24'h00_0000, {4{2'(c)}}});
      xfer(1'b0, pfm_pkg::PORT_B_HIGH_PIN_SELECT_ADDR, 32'h0000_0000);
      chk(rd, {24'h00_0000, {4{2'(c)}}});
      xfer(1'b0, pfm_pkg::PORT_A_HIGH_PIN_SELECT_ADDR, 32'h0000_0000);
      chk(rd, {24'h00_0000, {4{2'(c)}}});
      for (p = 0; p < 4; p++) begin
        // outputs have stood still for two cycles here, so the edge-time read is safe
        ph <= 2'(p);
        repeat (3) @(posedge clk_i);
        check_pins(2'(c), 2'(p));
      end
    end
    // peripheral drive back to phase 0 (serial tx drive low) before the fields return to gpio
    ph <= 2'h0;
    xfer(1'b1, pfm_pkg::PORT_A_HIGH_PIN_SELECT_ADDR, 32'h0000_0000);
    xfer(1'b1, pfm_pkg::PORT_B_HIGH_PIN_SELECT_ADDR, 32'h0000_0000);
    gpio_dir <= 8'hFF;
    for (c = 0; c < 2; c++) begin
      ext <= c[0] ? 8'h69 : 8'h96;
      repeat (5) @(posedge clk_i);
      chk(gpio_in, ext);
      chk(r, {1'b0, ext[4], ext[7], ext[5], ext[6], ext[0], ext[1], ext[2], ext[2], ext[3], ext[3]});
    end
    gpio_dir <= 8'h00;
    repeat (5) @(posedge clk_i);
    chk(r, 11'h000);
    gpio_dir <= 8'hFF;
    // a high level on the shared serial line, so the receive path is really seen
    ext <= 8'h96;
    xfer(1'b1, pfm_pkg::PORT_B_HIGH_PIN_SELECT_ADDR, 32'h0000_0002);
    repeat (5) @(posedge clk_i);
    chk(r[10:9], {ext[4], 1'b0});
    summarize();
  end
endmodule : pfm_port_ab_mux_test
`default_nettype wire
